// *** bench/tcd_pe_model.sv ***
`timescale 1ns/1ns
// stand-in for the traced processing element: it turns one-cycle requests
// of the bench into element pulses and keeps quiet while reset is held
module tcd_pe_model (
  input wire logic rst,        // reset, high
  input wire logic [6:0] req,  // pulse requests
  output logic [6:0] pulse     // commit, waypoint, resolve, txn start/end, pe reset, overflow
);
  // requests change just after an edge, so the pulses do as well
  always_comb begin
    pulse = rst ? 7'h00 : req;
  end
endmodule

// *** bench/test_trace_cycle_discard_branch.sv ***
`timescale 1ns/1ns
module test_trace_cycle_discard_branch;
  import tcd_pkg::*;
  localparam int CM = 0;
  localparam int WP = 1;
  localparam int RS = 2;
  localparam int TS = 3;
  localparam int TE = 4;
  localparam int PR = 5;
  localparam int OV = 6;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack;
  logic [6:0] req = 7'h00;
  logic [6:0] pl;
  logic busy = 1'b0;
  logic bv = 1'b0;
  logic bd = 1'b0;
  logic bt = 1'b0;
  logic [7:0] arc = 8'h00;
  logic [31:0] btgt = 32'h00000000;
  logic [31:0] taddr;
  logic ccv, dsc, wpo, tso, tro, tgv, rsb;
  logic tgv2, rsb2;
  logic [15:0] ccval;
  logic [31:0] cfg;
  logic [8:0] bbc;
  logic act;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  int n_disc = 0;
  int n_tr = 0;
  int d;

  always #5 ref_clk = ~ref_clk;

  tcd_pe_model pe (.rst(rst), .req(req), .pulse(pl));

  tcd_trace_unit dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .commit_i(pl[CM]), .waypoint_i(pl[WP]), .resolve_i(pl[RS]), .txn_start_i(pl[TS]),
    .txn_end_i(pl[TE]), .pe_reset_i(pl[PR]), .overflow_i(pl[OV]), .other_busy_i(busy),
    .br_valid_i(bv), .br_direct_i(bd), .br_taken_i(bt), .br_arc_i(arc), .br_target_i(btgt),
    .cc_valid_o(ccv), .cc_value_o(ccval), .discard_o(dsc), .waypoint_o(wpo), .txn_start_o(tso),
    .txn_result_o(tro), .tgt_valid_o(tgv), .tgt_addr_o(taddr), .rs_block_o(rsb));

  // same stimulus into a build without the broadcast control register
  tcd_trace_unit #(.BBCTL_PRESENT(1'b0)) dut_nb (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(), .wb_ack_o(),
    .commit_i(pl[CM]), .waypoint_i(pl[WP]), .resolve_i(pl[RS]), .txn_start_i(pl[TS]),
    .txn_end_i(pl[TE]), .pe_reset_i(pl[PR]), .overflow_i(pl[OV]), .other_busy_i(busy),
    .br_valid_i(bv), .br_direct_i(bd), .br_taken_i(bt), .br_arc_i(arc), .br_target_i(btgt),
    .cc_valid_o(), .cc_value_o(), .discard_o(), .waypoint_o(), .txn_start_o(),
    .txn_result_o(), .tgt_valid_o(tgv2), .tgt_addr_o(), .rs_block_o(rsb2));

  ////////////////////////////////////////////////////////////////////////////
  // pulse counters catch one-cycle elements we do not look at directly
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (dsc === 1'b1) n_disc <= n_disc + 1;
    if (tro === 1'b1) n_tr <= n_tr + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // classic cycle: held until ack is sampled high at an edge, released at that same edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dt;
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic pulse(input int b);
    @(posedge ref_clk);
    req[b] <= 1'b1;
    @(posedge ref_clk);
    req[b] <= 1'b0;
  endtask

  // one edge on; registered outputs are read as they stood through the cycle before it,
  // so a one-cycle element launched at the last edge is still caught
  task automatic look;
    @(posedge ref_clk);
  endtask

  // back-to-back commits are sampled three edges apart
  task automatic commit(input logic ev, input logic [15:0] evl);
    pulse(CM);
    look;
    chk(ccv, ev);
    if (ev) chk(ccval, evl);
  endtask

  function automatic logic bb_act(input logic [8:0] c, input logic [7:0] a);
    bb_act = c[BB_MODE_BIT] ? |(a & c[7:0]) : ~|(a & c[7:0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    d = $urandom(32'hdde8);
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values, read-only identification, unmapped place
    wb(1'b0, OFF_CONFIG, 32'h0);
    chk(rd, 32'h0);
    // threshold reads back its reset value, which equals the minimum
    wb(1'b0, OFF_THRESH, 32'h0);
    chk(rd, {16'h0, THRESH_RST});
    wb(1'b1, OFF_ID, 32'hffffffff);
    wb(1'b0, OFF_ID, 32'h0);
    chk(rd[4:0], CC_W_CODE);
    chk(rd[15:8], MIN_THRESH);
    wb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    // cycle counting with threshold 4
    wb(1'b1, OFF_CONFIG, 32'h5);
    repeat (8) @(posedge ref_clk);
    commit(1'b1, 16'h0);
    commit(1'b0, 16'h0);
    commit(1'b1, 16'h6);
    @(posedge ref_clk);
    commit(1'b1, 16'h4);
    for (int i = 0; i < 6; i++) begin
      d = $urandom_range(20, 1);
      repeat (d) @(posedge ref_clk);
      commit(1'b1, 16'(d + 3));
    end
    pulse(OV);
    commit(1'b1, 16'h0);
    wb(1'b1, OFF_CONFIG, 32'h4);
    commit(1'b0, 16'h0);
    // discard on processor reset
    pulse(WP);
    pulse(WP);
    pulse(RS);
    pulse(PR);
    look;
    chk(dsc, 1'b1);
    wb(1'b0, OFF_STATUS, 32'h0);
    chk(rd[7:0], 8'h00);
    d = n_disc;
    pulse(PR);
    repeat (3) look;
    chk(n_disc, d);
    // disable discard waits for other pending elements
    pulse(WP);
    busy <= 1'b1;
    wb(1'b1, OFF_CONFIG, 32'h0);
    repeat (4) look;
    chk(n_disc, d);
    busy <= 1'b0;
    repeat (3) look;
    chk(n_disc, d + 1);
    // transaction cut by a discard, then resumed before it ends
    wb(1'b1, OFF_CONFIG, 32'h4);
    pulse(TS);
    look;
    chk(tso, 1'b1);
    wb(1'b1, OFF_CONFIG, 32'h0);
    repeat (3) look;
    chk(n_disc, d + 2);
    wb(1'b1, OFF_CONFIG, 32'h4);
    pulse(WP);
    look;
    chk({tso, wpo}, 2'b10);
    look;
    chk(wpo, 1'b1);
    // the cut transaction ends hidden; a whole later one shows its outcome
    d = n_tr;
    pulse(TE);
    repeat (2) look;
    chk(n_tr, d);
    pulse(TS);
    pulse(TE);
    repeat (2) look;
    chk(n_tr, d + 1);
    // random branches over random broadcast settings and modes
    for (int i = 0; i < 40; i++) begin
      if (i % 8 == 0) begin
        bbc = 9'($urandom);
        cfg = ($urandom & 32'ha) | 32'h4;
        wb(1'b1, OFF_CONFIG, cfg);
        wb(1'b1, OFF_BBCTL, {23'h0, bbc});
        wb(1'b0, OFF_BBCTL, 32'h0);
        chk(rd, {23'h0, bbc});
      end
      @(posedge ref_clk);
      bv <= 1'b1;
      bd <= 1'($urandom_range(1, 0));
      bt <= 1'($urandom_range(1, 0));
      arc <= 8'($urandom);
      btgt <= $urandom;
      // the branch is sampled at the next edge, its elements read one edge later
      @(posedge ref_clk);
      bv <= 1'b0;
      look;
      act = bb_act(bbc, arc) & cfg[CFG_BB_EN];
      chk(tgv, act & bd & bt);
      if (act & bd & bt) chk(taddr, btgt);
      chk(rsb, act & cfg[CFG_RS_EN]);
      chk(tgv2, cfg[CFG_BB_EN] & bd & bt);
      chk(rsb2, cfg[CFG_BB_EN] & cfg[CFG_RS_EN]);
    end
    close_out();
  end
endmodule

// *** rtl/tcd_pkg.sv ***
package tcd_pkg;
  // cycle counter geometry; the width code is what software reads back
  localparam int CC_W = 16;
  localparam logic [4:0] CC_W_CODE = 5'h10;
  localparam logic [15:0] CC_MAX = 16'hffff;
  localparam logic [15:0] CC_ONE = 16'h0001;
  localparam logic [15:0] CC_ZERO = 16'h0000;
  localparam logic [7:0] MIN_THRESH = 8'h04;
  localparam int DEPTH_W = 8;
  localparam int RANGE_W = 8;
  // register byte offsets
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_THRESH = 8'h04;
  localparam logic [7:0] OFF_BBCTL = 8'h08;
  localparam logic [7:0] OFF_ID = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  // config bit positions
  localparam int CFG_CC_EN = 0;
  localparam int CFG_BB_EN = 1;
  localparam int CFG_TRACE_EN = 2;
  localparam int CFG_RS_EN = 3;
  // broadcast control: ranges in [7:0], include mode in bit 8
  localparam int BB_MODE_BIT = 8;
  // identification field positions
  localparam int ID_CCW_LSB = 0;
  localparam int ID_MIN_LSB = 8;
  localparam int ID_BB_BIT = 16;
  // status field positions
  localparam int ST_TXN_BIT = 8;
  localparam int ST_UNK_BIT = 9;
  localparam int ST_PEND_BIT = 10;
  localparam int ST_RESTART_BIT = 11;
  // values after reset
  localparam logic [3:0] CONFIG_RST = 4'h0;
  localparam logic [15:0] THRESH_RST = 16'h0004;
  localparam logic [8:0] BBCTL_RST = 9'h000;
endpackage

// *** rtl/tcd_trace_unit.sv ***
// What this block does
// - counter width fixed, reported read-only
// - commit at or above threshold requests count
// - count element emitted before any later commit
// - always emit immediately, never defer
// - emit captured value, reload elapsed cycles
// - emitted zero means count unknown
// - counter beyond maximum reports unknown
// - first count after enable unknown
// - first count after overflow unknown
// - going inoperative with speculation emits discard
// - disable discard waits for pending elements
// - processor reset with speculation emits discard
// - no discard when nothing speculative
// - discard clears speculation depth
// - after discard hide transaction outcome
// - fresh transaction start before resumed waypoints
// - include inside ranges, exclude outside
// - taken direct branch emits target address
// - broadcast blocks return stack match
// - no control register means always active
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
module tcd_trace_unit #(
  parameter bit BBCTL_PRESENT = 1'b1       // broadcast control register built
) (
  input wire logic ref_clk,                // processor clock
  input wire logic rst,                    // synchronous reset, high
  input wire logic wb_cyc_i,               // wishbone cycle
  input wire logic wb_stb_i,               // wishbone strobe
  input wire logic wb_we_i,                // wishbone write
  input wire logic [7:0] wb_adr_i,         // wishbone byte address
  input wire logic [3:0] wb_sel_i,         // wishbone byte enables
  input wire logic [31:0] wb_dat_i,        // wishbone write data
  output logic [31:0] wb_dat_o,            // wishbone read data
  output logic wb_ack_o,                   // wishbone acknowledge
  input wire logic commit_i,               // commit element produced
  input wire logic waypoint_i,             // new speculative waypoint
  input wire logic resolve_i,              // one waypoint resolved
  input wire logic txn_start_i,            // transaction start
  input wire logic txn_end_i,              // transaction success or failure
  input wire logic pe_reset_i,             // processor reset pulse
  input wire logic overflow_i,             // trace buffer overflow
  input wire logic other_busy_i,           // other elements still pending
  input wire logic br_valid_i,             // branch retired
  input wire logic br_direct_i,            // branch is direct
  input wire logic br_taken_i,             // branch taken
  input wire logic [tcd_pkg::RANGE_W-1:0] br_arc_i, // address range hits
  input wire logic [31:0] br_target_i,     // branch target
  output logic cc_valid_o,                 // cycle count element
  output logic [tcd_pkg::CC_W-1:0] cc_value_o, // count, zero is unknown
  output logic discard_o,                  // discard element
  output logic waypoint_o,                 // waypoint element
  output logic txn_start_o,                // transaction start element
  output logic txn_result_o,               // transaction outcome element
  output logic tgt_valid_o,                // target address element
  output logic [31:0] tgt_addr_o,          // target address
  output logic rs_block_o                  // return stack must not match
);
  import tcd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // register file
  logic [3:0] cfg;
  logic [CC_W-1:0] thresh;
  logic [8:0] bbctl;
  logic [CC_W-1:0] cnt;
  logic unknown;
  logic [DEPTH_W-1:0] depth;
  logic txn_open;
  logic disc_pend;
  logic need_restart;
  logic txn_blk;
  logic tr_en_q;
  logic wp_q;

  // merge write data under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic req;
  logic wr;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;
  logic wr_cfg;
  assign wr_cfg = wr && (wb_adr_i == OFF_CONFIG);

  logic [31:0] next_cfg;
  logic [31:0] next_thresh;
  logic [31:0] next_bbctl;
  assign next_cfg = merge({28'h0000000, cfg}, wb_dat_i, wb_sel_i);
  assign next_thresh = merge({16'h0000, thresh}, wb_dat_i, wb_sel_i);
  assign next_bbctl = merge({23'h000000, bbctl}, wb_dat_i, wb_sel_i);

  // software writes; unmapped and read-only offsets ignore writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg <= CONFIG_RST;
      thresh <= THRESH_RST;
      bbctl <= BBCTL_RST;
    end else if (wr) begin
      case (wb_adr_i)
        OFF_CONFIG: cfg <= next_cfg[3:0];
        OFF_THRESH: thresh <= next_thresh[CC_W-1:0];
        OFF_BBCTL: bbctl <= next_bbctl[8:0];
        default: ;
      endcase
    end
  end

  // one wait state: ack registered, dropped the cycle after
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // read data, unmapped reads return zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (req && !wb_we_i) begin
      case (wb_adr_i)
        OFF_CONFIG: wb_dat_o <= {28'h0000000, cfg};
        OFF_THRESH: wb_dat_o <= {16'h0000, thresh};
        OFF_BBCTL: wb_dat_o <= BBCTL_PRESENT ? {23'h000000, bbctl} : 32'h00000000;
        OFF_ID: begin
          wb_dat_o <= 32'h00000000;
          wb_dat_o[ID_CCW_LSB +: 5] <= CC_W_CODE;
          wb_dat_o[ID_MIN_LSB +: 8] <= MIN_THRESH;
          wb_dat_o[ID_BB_BIT] <= BBCTL_PRESENT;
        end
        OFF_STATUS: begin
          wb_dat_o <= 32'h00000000;
          wb_dat_o[DEPTH_W-1:0] <= depth;
          wb_dat_o[ST_TXN_BIT] <= txn_open;
          wb_dat_o[ST_UNK_BIT] <= unknown;
          wb_dat_o[ST_PEND_BIT] <= disc_pend;
          wb_dat_o[ST_RESTART_BIT] <= need_restart;
        end
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cycle counting
  logic tr_en;
  logic cc_en;
  assign tr_en = cfg[CFG_TRACE_EN];
  assign cc_en = cfg[CFG_CC_EN] && tr_en;

  // threshold compare; below-minimum threshold is software's concern
  logic cc_req;
  assign cc_req = cc_en && commit_i && (cnt >= thresh);
  logic exceed;
  assign exceed = cc_en && (cnt == CC_MAX) && !cc_req;

  always_ff @(posedge ref_clk) begin
    tr_en_q <= rst ? 1'b0 : tr_en;
  end

  // free count, saturating at the top value
  always_ff @(posedge ref_clk) begin
    if (rst || !cc_en) begin
      cnt <= CC_ZERO;
    end else if (cc_req) begin
      // reload with cycles since this commit
      cnt <= CC_ONE;
    end else if (cnt != CC_MAX) begin
      cnt <= cnt + CC_ONE;
    end
  end

  // unknown flag; any new cause wins over the clear by an emission
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      unknown <= 1'b1;
    end else if ((tr_en && !tr_en_q) || overflow_i || exceed) begin
      unknown <= 1'b1;
    end else if (cc_req) begin
      unknown <= 1'b0;
    end
  end

  // emitted in the cycle after its commit, never deferred
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cc_valid_o <= 1'b0;
      cc_value_o <= CC_ZERO;
    end else begin
      cc_valid_o <= cc_req;
      if (cc_req) begin
        cc_value_o <= unknown ? CC_ZERO : cnt;
      end
    end
  end

  a_cc_request: assert property (@(posedge ref_clk) disable iff (rst)
    cc_en && commit_i && (cnt >= thresh) |=> cc_valid_o) else $error("count request not emitted");
  a_cc_reload: assert property (@(posedge ref_clk) disable iff (rst)
    cc_req && !wr_cfg |=> cnt == CC_ONE ##1 (!cc_en || cc_req || cnt == 16'h0002))
    else $error("counter not reloaded");
  // an overflow, one quiet cycle, then a commit: the emission must read unknown
  a_cc_unknown: assert property (@(posedge ref_clk) disable iff (rst)
    overflow_i ##1 !cc_req ##1 (cc_req && !overflow_i) |=> cc_value_o == CC_ZERO)
    else $error("count after overflow not unknown");
  a_cc_value: assert property (@(posedge ref_clk) disable iff (rst)
    cc_req && !unknown |=> cc_value_o == $past(cnt)) else $error("wrong count value");
  a_cc_silent: assert property (@(posedge ref_clk) disable iff (rst)
    !cc_en |=> !cc_valid_o) else $error("count element while counting off");
  a_cc_zero: assert property (@(posedge ref_clk) disable iff (rst)
    cc_req && unknown |=> cc_value_o == CC_ZERO) else $error("unknown count not sent as zero");
  a_cc_enable: assert property (@(posedge ref_clk) disable iff (rst)
    tr_en && !tr_en_q |=> unknown) else $error("enable did not mark count unknown");
  a_cc_exceed: assert property (@(posedge ref_clk) disable iff (rst)
    cc_en && (cnt == CC_MAX) && !commit_i |=> unknown) else $error("saturated count not unknown");
  a_cnt_step: assert property (@(posedge ref_clk) disable iff (rst)
    cc_en && !cc_req && (cnt != CC_MAX) && !wr_cfg |=> cnt == $past(cnt) + CC_ONE)
    else $error("counter did not step");
  a_cnt_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !cc_en |=> cnt == CC_ZERO) else $error("counter not cleared while off");

  ////////////////////////////////////////////////////////////////////////
  // speculation and discard
  logic spec;
  assign spec = (depth != 8'h00) || txn_open;
  logic disc_fire;
  // reset discard, disable discard after others drain
  assign disc_fire = (pe_reset_i && spec) || (disc_pend && !other_busy_i);

  // disable with speculation arms a discard; none if idle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      disc_pend <= 1'b0;
    end else if (!tr_en && tr_en_q && spec) begin
      disc_pend <= 1'b1;
    end else if (disc_fire) begin
      disc_pend <= 1'b0;
    end
  end

  // depth tracking
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      depth <= 8'h00;
    end else if (disc_fire) begin
      depth <= 8'h00;
    end else if (tr_en) begin
      depth <= depth + {7'h00, waypoint_i} - {7'h00, resolve_i && (depth != 8'h00)};
    end
  end

  // transaction open tracking; a processor reset ends it
  always_ff @(posedge ref_clk) begin
    if (rst || pe_reset_i) begin
      txn_open <= 1'b0;
    end else if (txn_start_i) begin
      txn_open <= 1'b1;
    end else if (txn_end_i) begin
      txn_open <= 1'b0;
    end
  end

  // outcome hidden once a discard cut an open transaction
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txn_blk <= 1'b0;
    end else if (disc_fire && txn_open && !pe_reset_i) begin
      txn_blk <= 1'b1;
    end else if (txn_end_i || txn_start_i || pe_reset_i) begin
      txn_blk <= 1'b0;
    end
  end

  // resumed transaction needs a fresh start element
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      need_restart <= 1'b0;
    end else if (disc_fire && txn_open && !pe_reset_i) begin
      need_restart <= 1'b1;
    end else if ((tr_en && waypoint_i) || txn_start_i || txn_end_i || pe_reset_i) begin
      need_restart <= 1'b0;
    end
  end

  // waypoints lag one cycle so a fresh start can lead them
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wp_q <= 1'b0;
      waypoint_o <= 1'b0;
      txn_start_o <= 1'b0;
      txn_result_o <= 1'b0;
      discard_o <= 1'b0;
    end else begin
      wp_q <= tr_en && waypoint_i;
      waypoint_o <= wp_q;
      // start element ahead of the waypoint
      txn_start_o <= tr_en && (txn_start_i || (need_restart && waypoint_i));
      txn_result_o <= tr_en && txn_end_i && !txn_blk;
      discard_o <= disc_fire;
    end
  end

  a_disc_reset: assert property (@(posedge ref_clk) disable iff (rst)
    pe_reset_i && (depth != 8'h00) |=> discard_o && depth == 8'h00)
    else $error("reset discard missing");
  a_disc_order: assert property (@(posedge ref_clk) disable iff (rst)
    disc_pend && other_busy_i && !pe_reset_i |=> !discard_o) else $error("discard ahead of pending");
  a_disc_disable: assert property (@(posedge ref_clk) disable iff (rst)
    !tr_en && tr_en_q && spec && !other_busy_i ##1 !other_busy_i |=> discard_o)
    else $error("disable discard missing");
  a_txn_hidden: assert property (@(posedge ref_clk) disable iff (rst)
    txn_blk && txn_end_i |=> !txn_result_o) else $error("outcome shown after discard");
  a_txn_restart: assert property (@(posedge ref_clk) disable iff (rst)
    tr_en && need_restart && waypoint_i |=> txn_start_o && !waypoint_o ##1 waypoint_o)
    else $error("start not before waypoint");
  a_disc_depth: assert property (@(posedge ref_clk) disable iff (rst)
    disc_fire |=> depth == 8'h00) else $error("depth kept after discard");
  a_disc_idle: assert property (@(posedge ref_clk) disable iff (rst)
    pe_reset_i && !spec && !disc_pend |=> !discard_o) else $error("discard with nothing speculative");

  ////////////////////////////////////////////////////////////////////////
  // branch broadcasting
  logic bb_hit;
  logic bb_active;
  assign bb_hit = |(br_arc_i & bbctl[RANGE_W-1:0]);
  // include or exclude; always active without the register
  assign bb_active = cfg[CFG_BB_EN] && (!BBCTL_PRESENT || (bbctl[BB_MODE_BIT] ? bb_hit : !bb_hit));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tgt_valid_o <= 1'b0;
      tgt_addr_o <= 32'h00000000;
      rs_block_o <= 1'b0;
    end else begin
      tgt_valid_o <= tr_en && br_valid_i && br_direct_i && br_taken_i && bb_active;
      if (tr_en && br_valid_i && br_direct_i && br_taken_i && bb_active) begin
        tgt_addr_o <= br_target_i;
      end
      // broadcast wins over the return stack
      rs_block_o <= br_valid_i && bb_active && cfg[CFG_RS_EN];
    end
  end

  a_bb_target: assert property (@(posedge ref_clk) disable iff (rst)
    tr_en && br_valid_i && br_direct_i && br_taken_i && bb_active |=> tgt_valid_o && tgt_addr_o == $past(br_target_i))
    else $error("broadcast target missing");
  a_bb_mode: assert property (@(posedge ref_clk) disable iff (rst)
    tgt_valid_o |-> $past(cfg[CFG_BB_EN]) && (!BBCTL_PRESENT || ($past(bbctl[BB_MODE_BIT]) == $past(bb_hit))))
    else $error("broadcast outside selected region");
  a_rs_block: assert property (@(posedge ref_clk) disable iff (rst)
    br_valid_i && bb_active && cfg[CFG_RS_EN] |=> rs_block_o) else $error("return stack not blocked");
  a_bb_off: assert property (@(posedge ref_clk) disable iff (rst)
    !cfg[CFG_BB_EN] |=> !tgt_valid_o) else $error("target element while broadcast off");
  a_rs_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !cfg[CFG_RS_EN] |=> !rs_block_o) else $error("return stack blocked while off");
  a_wb_ack: assert property (@(posedge ref_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
endmodule
